/* File: core/netind_pkg.sv */
// How it works
// - Transmit indicator is held high about 50 ms after each transmit.
// - Collision indicator is held high about 50 ms after each collision.
// - Link pin role is sampled once, when the chip reset is released.
// - A floating or lamp-loaded link pin at release becomes open-drain output.
// - As output with an intact twisted-pair link, the pin is pulled low.
// - A broken twisted-pair link switches the open-drain driver off unless software forces link checking off.
// - With the AUI port selected, the link pin stays released.
// - A link pin held low at release is an input; link checking is off.
// - Squelch select low gives standard threshold, high the reduced one.
// - A 20 MHz clock divided from the core clock is driven on its own output.
// - Idle select high makes AUI outputs equal; low keeps positive higher.
// - Media port select high routes the codec to AUI, low to twisted pair.
package netind_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_FREQ_HZ = 200_000_000;
  localparam int unsigned STRETCH_TIME_MS = 50;
  localparam int unsigned STRETCH_CYCLES =
    CLK_FREQ_HZ / 1000 * STRETCH_TIME_MS;
  localparam int unsigned STRETCH_CNT_W = 24;
  localparam int unsigned AUX_CLK_FREQ_HZ = 20_000_000;
  localparam int unsigned AUX_HALF_CYCLES =
    CLK_FREQ_HZ / AUX_CLK_FREQ_HZ / 2;
  localparam int unsigned AUX_DIV_W = 3;
  localparam logic [AUX_DIV_W-1:0] AUX_DIV_LAST =
    AUX_DIV_W'(AUX_HALF_CYCLES - 1);
  localparam logic [AUX_DIV_W-1:0] AUX_DIV_RESET = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned NUM_PINS = 5;
  localparam int unsigned PIN_MEDIA = 0;
  localparam int unsigned PIN_SQUELCH = 1;
  localparam int unsigned PIN_IDLE = 2;
  localparam int unsigned PIN_TEST = 3;
  localparam int unsigned PIN_LINK = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;
  localparam int unsigned CTRL_W = 2;
  localparam int unsigned CTRL_FORCE_OFF_BIT = 0;
  localparam int unsigned CTRL_LAMP_TEST_BIT = 1;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
  localparam int unsigned ST_STRAP_INPUT_BIT = 0;
  localparam int unsigned ST_LINK_INTACT_BIT = 1;
  localparam int unsigned ST_TX_IND_BIT = 2;
  localparam int unsigned ST_COL_IND_BIT = 3;
  localparam int unsigned ST_AUI_BIT = 4;
  localparam int unsigned ST_SQUELCH_BIT = 5;
  localparam int unsigned ST_IDLE_EQ_BIT = 6;
  localparam int unsigned ST_TEST_PIN_BIT = 7;
  localparam int unsigned ST_CHECK_EN_BIT = 8;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture sequence
  typedef enum logic [2:0] {
    ST_HOLD   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_RUN    = 3'b100
  } strap_state_e;

endpackage

/* File: core/activity_stretch.sv */
`timescale 1ns/10ps
module activity_stretch
  import netind_pkg::*;
#(
  parameter int unsigned CNT_W = STRETCH_CNT_W,
  parameter logic [CNT_W-1:0] LOAD = CNT_W'(STRETCH_CYCLES)
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_event,
  output logic o_active
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic active_reg;
  logic active_next;

  ////////////////////////////////////////////////////////////////////////////
  // Countdown; a new event restarts it even mid-stretch
  always_comb
  begin
    cnt_next = cnt_reg;
    if (i_event)
    begin
      cnt_next = LOAD;
    end
    else if (cnt_reg != '0)
    begin
      cnt_next = cnt_reg - 1'b1;
    end
    active_next = (cnt_next != '0);
  end

  // State registers
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt_reg <= '0;
      active_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      active_reg <= active_next;
    end
  end

  assign o_active = active_reg;

endmodule // activity_stretch

/* File: core/network_status_indicators.sv */
// Our own choices: the address map and the APB register port.
`timescale 1ns/10ps
module network_status_indicators
  import netind_pkg::*;
#(
  parameter int unsigned STRETCH_LEN = STRETCH_CYCLES
)
(
  input wire logic I_CLK,
  input wire logic I_RST,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Events from codec and link monitor, same clock
  input wire logic I_TX_EVENT,
  input wire logic I_COL_EVENT,
  input wire logic I_LINK_INTACT,
  // Pins, asynchronous
  input wire logic I_MEDIA_PORT_SELECT,
  input wire logic I_SQUELCH_LEVEL_SELECT,
  input wire logic I_IDLE_LEVEL_SELECT,
  input wire logic I_FACTORY_TEST,
  input wire logic I_LINK_GOOD_OR_DISABLE_PIN_I,
  // Outputs
  output logic O_TRANSMIT_ACTIVITY_INDICATOR,
  output logic O_COLLISION_INDICATOR,
  output logic O_LINK_GOOD_OR_DISABLE_PIN_O,
  output logic O_LINK_GOOD_OR_DISABLE_PIN_OE,
  output logic O_LINK_CHECK_ENABLE,
  output logic O_SQUELCH_REDUCED,
  output logic O_AUI_IDLE_EQUAL,
  output logic O_AUI_SELECTED,
  output logic O_CLK_20MHZ
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] sync1_reg;
  logic [NUM_PINS-1:0] sync2_reg;
  logic [NUM_PINS-1:0] sync3_reg;
  logic [NUM_PINS-1:0] filt_reg;
  logic [NUM_PINS-1:0] filt_next;
  strap_state_e strap_reg;
  strap_state_e strap_next;
  logic out_mode_reg;
  logic out_mode_next;
  logic [1:0] act_event;
  logic [1:0] act_on;
  logic tx_ind_reg;
  logic tx_ind_next;
  logic col_ind_reg;
  logic col_ind_next;
  logic link_oe_reg;
  logic link_oe_next;
  logic link_o_reg;
  logic check_en_reg;
  logic check_en_next;
  logic squelch_reg;
  logic squelch_next;
  logic idle_eq_reg;
  logic idle_eq_next;
  logic aui_reg;
  logic aui_next;
  logic [AUX_DIV_W-1:0] div_reg;
  logic [AUX_DIV_W-1:0] div_next;
  logic aux_clk_reg;
  logic aux_clk_next;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [CTRL_W-1:0] ctrl_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [31:0] status_word;
  logic [1:0] sel;
  logic access;

  ////////////////////////////////////////////////////////////////////////////
  // One-hot register select: bit 0 control, bit 1 status
  function automatic logic [1:0] decode_reg(input logic [ADDR_W-1:0] a);
    logic [1:0] r;
    r = 2'h0;
    if (a == CTRL_OFFSET)
    begin
      r[0] = 1'b1;
    end
    if (a == STATUS_OFFSET)
    begin
      r[1] = 1'b1;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; not reset so the strap is valid right at release
  assign pin_raw[PIN_MEDIA] = I_MEDIA_PORT_SELECT;
  assign pin_raw[PIN_SQUELCH] = I_SQUELCH_LEVEL_SELECT;
  assign pin_raw[PIN_IDLE] = I_IDLE_LEVEL_SELECT;
  assign pin_raw[PIN_TEST] = I_FACTORY_TEST;
  assign pin_raw[PIN_LINK] = I_LINK_GOOD_OR_DISABLE_PIN_I;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++)
    begin : g_pin
      // Change accepted only when stages two and three agree
      always_comb
      begin
        filt_next[gp] = filt_reg[gp];
        if (sync2_reg[gp] == sync3_reg[gp])
        begin
          filt_next[gp] = sync3_reg[gp];
        end
      end

      always_ff @(posedge I_CLK)
      begin
        sync1_reg[gp] <= pin_raw[gp];
        sync2_reg[gp] <= sync1_reg[gp];
        sync3_reg[gp] <= sync2_reg[gp];
        filt_reg[gp] <= filt_next[gp];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture: the link pin role is fixed once per reset release
  always_comb
  begin
    strap_next = strap_reg;
    out_mode_next = out_mode_reg;
    case (strap_reg)
      ST_HOLD:
      begin
        strap_next = ST_SAMPLE;
      end
      ST_SAMPLE:
      begin
        // Pull-up reads high when open or lamp-loaded
        out_mode_next = filt_reg[PIN_LINK];
        strap_next = ST_RUN;
      end
      ST_RUN:
      begin
        strap_next = ST_RUN;
      end
      default:
      begin
        strap_next = ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      strap_reg <= ST_HOLD;
      out_mode_reg <= 1'b0;
    end
    else
    begin
      strap_reg <= strap_next;
      out_mode_reg <= out_mode_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activity stretchers, transmit in slot 0 and collision in slot 1
  assign act_event = {I_COL_EVENT, I_TX_EVENT};

  genvar ga;
  generate
    for (ga = 0; ga < 2; ga++)
    begin : g_act
      activity_stretch #(
        .CNT_W(STRETCH_CNT_W),
        .LOAD(STRETCH_CNT_W'(STRETCH_LEN))
      ) u_stretch (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_event(act_event[ga]),
        .o_active(act_on[ga])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin-facing outputs; lamp test lights both indicators from software
  always_comb
  begin
    tx_ind_next = act_on[0] | ctrl_reg[CTRL_LAMP_TEST_BIT];
    col_ind_next = act_on[1] | ctrl_reg[CTRL_LAMP_TEST_BIT];
    aui_next = filt_reg[PIN_MEDIA];
    squelch_next = filt_reg[PIN_SQUELCH];
    idle_eq_next = filt_reg[PIN_IDLE];
    // Checking off when strapped as input or forced off by software
    check_en_next = out_mode_next
      & ~ctrl_reg[CTRL_FORCE_OFF_BIT];
    // Open-drain: enable pulls low; link taken as good when unchecked
    link_oe_next = out_mode_next
      & ~aui_next
      & (I_LINK_INTACT | ~check_en_next);
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      tx_ind_reg <= 1'b0;
      col_ind_reg <= 1'b0;
      aui_reg <= 1'b0;
      squelch_reg <= 1'b0;
      idle_eq_reg <= 1'b0;
      check_en_reg <= 1'b0;
      link_oe_reg <= 1'b0;
      link_o_reg <= 1'b0;
    end
    else
    begin
      tx_ind_reg <= tx_ind_next;
      col_ind_reg <= col_ind_next;
      aui_reg <= aui_next;
      squelch_reg <= squelch_next;
      idle_eq_reg <= idle_eq_next;
      check_en_reg <= check_en_next;
      link_oe_reg <= link_oe_next;
      link_o_reg <= 1'b0; // Open-drain data is always low
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock output, divided from the core clock
  always_comb
  begin
    div_next = div_reg + 1'b1;
    aux_clk_next = aux_clk_reg;
    if (div_reg == AUX_DIV_LAST)
    begin
      div_next = AUX_DIV_RESET;
      aux_clk_next = ~aux_clk_reg;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      div_reg <= AUX_DIV_RESET;
      aux_clk_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      aux_clk_reg <= aux_clk_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave; one wait state so every bus output leaves a flop
  assign sel = decode_reg(I_PADDR);
  assign access = I_PSEL & I_PENABLE & pready_reg;

  always_comb
  begin
    status_word = DATA_RESET;
    status_word[ST_STRAP_INPUT_BIT] = ~out_mode_reg;
    status_word[ST_LINK_INTACT_BIT] = I_LINK_INTACT;
    status_word[ST_TX_IND_BIT] = tx_ind_reg;
    status_word[ST_COL_IND_BIT] = col_ind_reg;
    status_word[ST_AUI_BIT] = aui_reg;
    status_word[ST_SQUELCH_BIT] = squelch_reg;
    status_word[ST_IDLE_EQ_BIT] = idle_eq_reg;
    status_word[ST_TEST_PIN_BIT] = filt_reg[PIN_TEST];
    status_word[ST_CHECK_EN_BIT] = check_en_reg;
  end

  always_comb
  begin
    ctrl_next = ctrl_reg;
    pready_next = I_PSEL & I_PENABLE & ~pready_reg;
    pslverr_next = 1'b0;
    prdata_next = DATA_RESET;
    if (pready_next)
    begin
      pslverr_next = (sel == 2'h0);
      if (!I_PWRITE && sel[1])
      begin
        prdata_next = status_word;
      end
      else if (!I_PWRITE && sel[0])
      begin
        prdata_next = {{(32 - CTRL_W){1'b0}}, ctrl_reg};
      end
    end
    // Write lands only at the completing edge
    if (access && I_PWRITE && sel[0])
    begin
      ctrl_next = I_PWDATA[CTRL_W-1:0];
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      ctrl_reg <= CTRL_RESET;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= DATA_RESET;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drive
  assign O_PRDATA = prdata_reg;
  assign O_PREADY = pready_reg;
  assign O_PSLVERR = pslverr_reg;
  assign O_TRANSMIT_ACTIVITY_INDICATOR = tx_ind_reg;
  assign O_COLLISION_INDICATOR = col_ind_reg;
  assign O_LINK_GOOD_OR_DISABLE_PIN_O = link_o_reg;
  assign O_LINK_GOOD_OR_DISABLE_PIN_OE = link_oe_reg;
  assign O_LINK_CHECK_ENABLE = check_en_reg;
  assign O_SQUELCH_REDUCED = squelch_reg;
  assign O_AUI_IDLE_EQUAL = idle_eq_reg;
  assign O_AUI_SELECTED = aui_reg;
  assign O_CLK_20MHZ = aux_clk_reg;

endmodule // network_status_indicators

/* File: dv/netind_checker.sv */
`timescale 1ns/10ps
module netind_checker
  import netind_pkg::*;
#(
  parameter int unsigned STRETCH_LEN = STRETCH_CYCLES
)
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic O_PREADY,
  input wire logic I_TX_EVENT,
  input wire logic I_COL_EVENT,
  input wire logic I_LINK_INTACT,
  input wire logic I_MEDIA_PORT_SELECT,
  input wire logic I_SQUELCH_LEVEL_SELECT,
  input wire logic I_IDLE_LEVEL_SELECT,
  input wire logic I_LINK_GOOD_OR_DISABLE_PIN_I,
  input wire logic O_TRANSMIT_ACTIVITY_INDICATOR,
  input wire logic O_COLLISION_INDICATOR,
  input wire logic O_LINK_GOOD_OR_DISABLE_PIN_OE,
  input wire logic O_LINK_CHECK_ENABLE,
  input wire logic O_SQUELCH_REDUCED,
  input wire logic O_AUI_IDLE_EQUAL,
  input wire logic O_AUI_SELECTED,
  input wire logic O_CLK_20MHZ
);
  logic [31:0] tx_reg, tx_next;
  logic [1:0] rel_reg, rel_next, ctrl_reg, ctrl_next;
  logic strap_reg, strap_next;
  wire logic oe = O_LINK_GOOD_OR_DISABLE_PIN_OE;
  wire logic lce = O_LINK_CHECK_ENABLE;
  wire logic aui = O_AUI_SELECTED;
  wire logic txi = O_TRANSMIT_ACTIVITY_INDICATOR;

  ////////////////////////////////////////
  // Event age, release count, strap copy and a shadow of the control bits
  always_comb
  begin
    tx_next = I_TX_EVENT ? 32'h0 : tx_reg + {31'h0, ~&tx_reg};
    rel_next = rel_reg + {1'b0, ~rel_reg[1]};
    strap_next = (rel_reg == 2'h1) ? ~I_LINK_GOOD_OR_DISABLE_PIN_I : strap_reg;
    ctrl_next = ctrl_reg;
    if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == CTRL_OFFSET)
      ctrl_next = I_PWDATA[1:0];
  end

  // Saturating age so an old event never wraps into a fresh one
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      tx_reg <= '1;
      rel_reg <= 2'h0;
      strap_reg <= 1'b0;
      ctrl_reg <= 2'h0;
    end
    else
    begin
      tx_reg <= tx_next;
      rel_reg <= rel_next;
      strap_reg <= strap_next;
      ctrl_reg <= ctrl_next;
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  sequence clk_hi5; O_CLK_20MHZ [*5]; endsequence
  sequence clk_lo5; !O_CLK_20MHZ [*5]; endsequence

  AST_TX_RISE: assert property (I_TX_EVENT |-> ##2 txi)
    else $error("Transmit indicator not raised");
  AST_COL_RISE: assert property (
    I_COL_EVENT |-> ##2 O_COLLISION_INDICATOR)
    else $error("Collision indicator not raised");
  AST_TX_DROP: assert property (
    tx_reg >= STRETCH_LEN + 4 && !ctrl_reg[1] && !$past(ctrl_reg[1])
    |-> !txi)
    else $error("Transmit indicator held too long");
  AST_RETRIG: assert property ($fell(txi) |-> tx_reg >= STRETCH_LEN)
    else $error("Transmit indicator dropped early");
  AST_OE_GOOD: assert property (
    lce && $past(lce) && $past(I_LINK_INTACT) && !aui && !$past(aui)
    |-> oe)
    else $error("Link lamp not driven");
  AST_OE_BROKEN: assert property (
    !$past(I_LINK_INTACT) && !ctrl_reg[0] && !$past(ctrl_reg[0])
    && !$past(ctrl_reg[0], 2) |-> !oe)
    else $error("Link lamp driven with broken link");
  AST_OE_AUI: assert property (aui && $past(aui) |-> !oe)
    else $error("Link pin driven in AUI mode");
  AST_STRAP_IN: assert property (strap_reg |-> !oe && !lce)
    else $error("Strapped input still checks link");
  AST_STRAP_OUT: assert property (
    rel_reg[1] && $past(rel_reg[1]) && !strap_reg && !ctrl_reg[0]
    && !$past(ctrl_reg[0]) && !$past(ctrl_reg[0], 2) |-> lce)
    else $error("Strapped output lost link check");
  AST_CLK: assert property (
    $rose(O_CLK_20MHZ) |-> clk_hi5 ##1 clk_lo5 ##1 O_CLK_20MHZ)
    else $error("Clock output period wrong");
  AST_SQ: assert property (
    $stable(I_SQUELCH_LEVEL_SELECT) [*7]
    |-> O_SQUELCH_REDUCED == I_SQUELCH_LEVEL_SELECT)
    else $error("Squelch select not followed");
  AST_IDLE: assert property (
    $stable(I_IDLE_LEVEL_SELECT) [*7]
    |-> O_AUI_IDLE_EQUAL == I_IDLE_LEVEL_SELECT)
    else $error("Idle select not followed");
  AST_MEDIA: assert property (
    $stable(I_MEDIA_PORT_SELECT) [*7] |-> aui == I_MEDIA_PORT_SELECT)
    else $error("Media select not followed");
endmodule // netind_checker

bind network_status_indicators netind_checker #(.STRETCH_LEN(STRETCH_LEN))
  netind_checker_i (.*);

/* File: dv/netind_pins.sv */
`timescale 1ns/10ps
module netind_pins
(
  input wire logic i_strap_low,
  input wire logic i_oe,
  input wire logic i_o,
  output logic o_link_pin,
  output logic o_test
);
  // Pull-up wins unless the board strap or the lamp driver pulls low
  assign o_link_pin = ~(i_strap_low | (i_oe & ~i_o));
  // Board keeps the test pin grounded
  assign o_test = 1'b0;
endmodule // netind_pins

/* File: dv/network_status_indicators_tb.sv */
`timescale 1ns/10ps
module network_status_indicators_tb;
  import netind_pkg::*;
  localparam int unsigned SL = 20;
  logic I_CLK, I_RST, I_PSEL, I_PENABLE, I_PWRITE, O_PREADY, O_PSLVERR;
  logic [ADDR_W-1:0] I_PADDR;
  logic [31:0] I_PWDATA, O_PRDATA, rd;
  logic I_TX_EVENT, I_COL_EVENT, I_LINK_INTACT, I_MEDIA_PORT_SELECT;
  logic I_SQUELCH_LEVEL_SELECT, I_IDLE_LEVEL_SELECT, I_FACTORY_TEST;
  logic I_LINK_GOOD_OR_DISABLE_PIN_I, O_TRANSMIT_ACTIVITY_INDICATOR;
  logic O_COLLISION_INDICATOR, O_LINK_GOOD_OR_DISABLE_PIN_O;
  logic O_LINK_GOOD_OR_DISABLE_PIN_OE, O_LINK_CHECK_ENABLE;
  logic O_SQUELCH_REDUCED, O_AUI_IDLE_EQUAL, O_AUI_SELECTED, O_CLK_20MHZ;
  logic strap_low, err, prev;
  logic [1:0] ind;
  int n_fail, compares, i, n;
  // Pin levels {media,squelch,idle} beside expected status bits [6:4]
  logic [5:0] rows [8] = '{6'h00, 6'h0C, 6'h12, 6'h1E, 6'h21, 6'h2D, 6'h33,
    6'h3F};

  assign ind = {O_COLLISION_INDICATOR, O_TRANSMIT_ACTIVITY_INDICATOR};
  network_status_indicators #(.STRETCH_LEN(SL)) network_status_indicators_i
    (.*);
  netind_pins netind_pins_i (.i_strap_low(strap_low),
    .i_oe(O_LINK_GOOD_OR_DISABLE_PIN_OE), .i_o(O_LINK_GOOD_OR_DISABLE_PIN_O),
    .o_link_pin(I_LINK_GOOD_OR_DISABLE_PIN_I), .o_test(I_FACTORY_TEST));

  ////////////////////////////////////////
  initial
  begin
    I_CLK = 1'b0;
    forever #2.5 I_CLK = ~I_CLK;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Sample just after the edge so its updates have landed
  task automatic tick(input int k);
    repeat (k) @(posedge I_CLK);
    #1;
  endtask

  // One APB transfer, held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge I_CLK);
    I_PSEL <= 1'b1;
    I_PWRITE <= wr;
    I_PADDR <= a;
    I_PWDATA <= d;
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    // No cycle count assumed; only the watchdog ends a stuck wait
    do
    begin
      @(posedge I_CLK);
    end
    while (O_PREADY !== 1'b1);
    rd = O_PRDATA;
    err = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask

  task automatic pulse(input int c);
    @(posedge I_CLK);
    I_TX_EVENT <= (c == 0);
    I_COL_EVENT <= (c == 1);
    @(posedge I_CLK);
    I_TX_EVENT <= 1'b0;
    I_COL_EVENT <= 1'b0;
  endtask

  // Strap level is held well past the release edge
  task automatic do_reset(input logic s);
    @(posedge I_CLK);
    strap_low <= s;
    I_RST <= 1'b1;
    repeat (4) @(posedge I_CLK);
    I_RST <= 1'b0;
    tick(8);
  endtask

  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////
  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #50000;
    n_fail++;
    end_of_test();
  end

  initial
  begin
    {I_RST, I_LINK_INTACT, strap_low} = 3'h6;
    {I_PSEL, I_PENABLE, I_PWRITE, I_TX_EVENT, I_COL_EVENT} = 5'h00;
    {I_MEDIA_PORT_SELECT, I_SQUELCH_LEVEL_SELECT, I_IDLE_LEVEL_SELECT} = 3'h0;
    I_PADDR = '0;
    I_PWDATA = '0;
    do_reset(1'b0);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    // Pin table: filtered levels, lamp driver and status readback
    for (i = 0; i < 8; i++)
    begin
      @(posedge I_CLK);
      {I_MEDIA_PORT_SELECT, I_SQUELCH_LEVEL_SELECT, I_IDLE_LEVEL_SELECT} <=
        rows[i][5:3];
      tick(10);
      chk({O_AUI_SELECTED, O_SQUELCH_REDUCED,
        O_AUI_IDLE_EQUAL}, rows[i][5:3]);
      chk(O_LINK_GOOD_OR_DISABLE_PIN_OE, !rows[i][5]);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk(rd[7:4], {1'b0, rows[i][2:0]});
    end
    @(posedge I_CLK);
    {I_MEDIA_PORT_SELECT, I_SQUELCH_LEVEL_SELECT, I_IDLE_LEVEL_SELECT} <= 3'h0;
    tick(10);
    // Stretch, retrigger part way through, then drop
    for (i = 0; i < 2; i++)
    begin
      pulse(i);
      tick(2);
      chk(ind[i], 1'b1);
      tick(SL - 8);
      pulse(i);
      tick(SL - 2);
      chk(ind[i], 1'b1);
      tick(6);
      chk(ind, 2'h0);
    end
    // Lamp test forces both indicators
    apb(1'b1, CTRL_OFFSET, 32'h0000_0002);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk(rd, 32'h0000_0002);
    tick(1);
    chk(ind, 2'h3);
    apb(1'b1, CTRL_OFFSET, 32'h0);
    // Broken link, forced off checking, then link restored
    @(posedge I_CLK);
    I_LINK_INTACT <= 1'b0;
    tick(3);
    chk({O_LINK_GOOD_OR_DISABLE_PIN_OE,
      I_LINK_GOOD_OR_DISABLE_PIN_I}, 2'h1);
    apb(1'b1, CTRL_OFFSET, 32'h0000_0001);
    tick(3);
    chk(O_LINK_GOOD_OR_DISABLE_PIN_OE, 1'b1);
    apb(1'b1, CTRL_OFFSET, 32'h0);
    tick(3);
    chk(O_LINK_GOOD_OR_DISABLE_PIN_OE, 1'b0);
    @(posedge I_CLK);
    I_LINK_INTACT <= 1'b1;
    tick(3);
    chk({O_LINK_GOOD_OR_DISABLE_PIN_OE,
      I_LINK_GOOD_OR_DISABLE_PIN_I}, 2'h2);
    // Ten rising edges across 100 cycle boundaries, whatever the phase
    n = 0;
    prev = O_CLK_20MHZ;
    repeat (101)
    begin
      @(posedge I_CLK);
      if (O_CLK_20MHZ === 1'b1 && prev === 1'b0)
        n++;
      prev = O_CLK_20MHZ;
    end
    chk(n, 10);
    // Strapped low: input role, checking off; then back to output
    do_reset(1'b1);
    chk({O_LINK_GOOD_OR_DISABLE_PIN_OE, O_LINK_CHECK_ENABLE}, 2'h0);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd[ST_STRAP_INPUT_BIT], 1'b1);
    do_reset(1'b0);
    chk({O_LINK_GOOD_OR_DISABLE_PIN_OE, O_LINK_CHECK_ENABLE}, 2'h3);
    end_of_test();
  end
endmodule // network_status_indicators_tb
